// file: verilog/idle_guard_receiver.sv
// Radio unit end: parses idle/guard messages from the octet link.
// Assumes the sender frames messages with last on the final octet.
`timescale 1ns/10ps

module idle_guard_receiver (
    input wire logic clock,
    input wire logic resetn,
    idle_guard_link_if.radio_unit link,
    output logic [63:0] transport,
    output idle_guard_pkg::hdr_t hdr,
    output logic hdr_valid,
    output idle_guard_pkg::sec_t sec,
    output logic sec_valid,
    output logic msg_done,
    output logic err_version,
    output logic err_kind,
    output logic err_length,
    output logic err_ext
);
    import idle_guard_pkg::*;

    typedef struct packed {
        rx_state_t st;
        logic [7:0] cnt;
        logic [7:0] left;
        logic [9:0] ext_left;
        logic ext_more;
        logic [63:0] transport;
        hdr_t hdr;
        sec_t sec;
        logic hdr_valid;
        logic sec_valid;
        logic done;
        logic err_version;
        logic err_kind;
        logic err_length;
        logic err_ext;
        logic ready;
    } rx_t;

    rx_t q_r;
    rx_t q_nxt;
    logic beat;
    logic [7:0] d;
    logic sec_end;
    logic finish;
    logic [7:0] ext_len;

    assign beat = link.valid && q_r.ready;
    assign d = link.data;

    // ==========================================
    // Octet parser
    always_comb begin
        q_nxt = q_r;
        q_nxt.hdr_valid = 1'b0;
        q_nxt.sec_valid = 1'b0;
        q_nxt.done = 1'b0;
        q_nxt.ready = 1'b1;
        sec_end = 1'b0;
        finish = 1'b0;
        ext_len = 8'h00;
        if (beat) begin
            q_nxt.cnt = q_r.cnt + 8'h01;
            unique case (q_r.st)
                RX_HDR: begin
                    if (q_r.cnt == 8'h00) begin
                        q_nxt.err_version = 1'b0;
                        q_nxt.err_kind = 1'b0;
                        q_nxt.err_length = 1'b0;
                        q_nxt.err_ext = 1'b0;
                    end
                    if (q_r.cnt < `IG_TRANSPORT_OCTETS) begin
                        q_nxt.transport = {q_r.transport[55:0], d};
                    end
                    unique case (q_r.cnt)
                        `IG_OCT_VERSION: begin
                            q_nxt.hdr.tx_rx_direction = d[7];
                            q_nxt.hdr.format_version = d[6:4];
                            q_nxt.hdr.channel_filter_select = d[3:0];
                        end
                        `IG_OCT_FRAME: q_nxt.hdr.radio_frame_number = d;
                        `IG_OCT_SLOT_HI: begin
                            q_nxt.hdr.subframe_number = d[7:4];
                            q_nxt.hdr.slot_number[5:2] = d[3:0];
                        end
                        `IG_OCT_SLOT_LO: begin
                            q_nxt.hdr.slot_number[1:0] = d[7:6];
                            q_nxt.hdr.first_symbol_number = d[5:0];
                        end
                        `IG_OCT_COUNT: q_nxt.hdr.section_count = d;
                        `IG_OCT_KIND: q_nxt.hdr.section_kind = d;
                        `IG_OCT_SHIFT_HI: q_nxt.hdr.timing_shift[15:8] = d;
                        `IG_OCT_SHIFT_LO: q_nxt.hdr.timing_shift[7:0] = d;
                        `IG_OCT_FFT: q_nxt.hdr.fft_and_spacing_code = d;
                        `IG_OCT_CP_HI: q_nxt.hdr.cyclic_prefix_size[15:8] = d;
                        `IG_OCT_CP_LO: q_nxt.hdr.cyclic_prefix_size[7:0] = d;
                        default: ;
                    endcase
                    if (q_r.cnt == `IG_OCT_RESERVED) begin
                        q_nxt.hdr_valid = 1'b1;
                        q_nxt.cnt = 8'h00;
                        q_nxt.left = q_r.hdr.section_count;
                        q_nxt.err_version = q_r.hdr.format_version != `IG_FORMAT_VERSION;
                        q_nxt.err_kind = q_r.hdr.section_kind != `IG_KIND_IDLE;
                        if (q_r.hdr.section_count == 8'h00) begin
                            finish = 1'b1;
                        end else begin
                            q_nxt.st = RX_SEC;
                        end
                    end
                end
                RX_SEC: begin
                    unique case (q_r.cnt)
                        `IG_SEC_TAG_HI: q_nxt.sec.section_tag[11:4] = d;
                        `IG_SEC_TAG_LO: begin
                            q_nxt.sec.section_tag[3:0] = d[7:4];
                            q_nxt.sec.alternate_block_indicator = d[3];
                            q_nxt.sec.symbol_step_command = d[2];
                            q_nxt.sec.first_block_index[9:8] = d[1:0];
                        end
                        `IG_SEC_BLOCK_LO: q_nxt.sec.first_block_index[7:0] = d;
                        `IG_SEC_COUNT: q_nxt.sec.block_count = d;
                        `IG_SEC_MASK_HI: q_nxt.sec.element_mask[11:4] = d;
                        `IG_SEC_MASK_LO: begin
                            q_nxt.sec.element_mask[3:0] = d[7:4];
                            q_nxt.sec.symbol_count = d[3:0];
                        end
                        `IG_SEC_FLAG: q_nxt.sec.more_extensions_flag = d[7];
                        default: ;
                    endcase
                    if (q_r.cnt == `IG_SEC_LAST) begin
                        q_nxt.sec_valid = 1'b1;
                        q_nxt.cnt = 8'h00;
                        if (q_r.sec.more_extensions_flag) begin
                            q_nxt.st = RX_EXT;
                        end else begin
                            sec_end = 1'b1;
                        end
                    end
                end
                RX_EXT: begin
                    if (q_r.cnt == 8'h00) begin
                        q_nxt.ext_more = d[7];
                        q_nxt.sec.extension_kind = d[6:0];
                    end else begin
                        ext_len = d;
                        if (d == 8'h00) begin
                            q_nxt.err_ext = 1'b1;
                            ext_len = 8'h01;
                        end
                        q_nxt.sec.extension_word_length = ext_len;
                        q_nxt.ext_left = {ext_len, 2'b00} - `IG_EXT_HDR_BYTES;
                        q_nxt.st = RX_SKIP;
                    end
                end
                RX_SKIP: begin
                    q_nxt.ext_left = q_r.ext_left - 10'h001;
                    if (q_r.ext_left == 10'h001) begin
                        q_nxt.cnt = 8'h00;
                        if (q_r.ext_more) begin
                            q_nxt.st = RX_EXT;
                        end else begin
                            sec_end = 1'b1;
                        end
                    end
                end
                RX_DRAIN: begin
                    if (link.last) begin
                        q_nxt.cnt = 8'h00;
                        q_nxt.st = RX_HDR;
                    end
                end
            endcase
            if (sec_end) begin
                q_nxt.left = q_r.left - 8'h01;
                if (q_r.left == 8'h01) begin
                    finish = 1'b1;
                end else begin
                    q_nxt.st = RX_SEC;
                end
            end
            // Message end against the link's last marker
            if (finish) begin
                q_nxt.done = 1'b1;
                q_nxt.cnt = 8'h00;
                if (link.last) begin
                    q_nxt.st = RX_HDR;
                end else begin
                    q_nxt.err_length = 1'b1;
                    q_nxt.st = RX_DRAIN;
                end
            end else if (link.last && q_r.st != RX_DRAIN) begin
                q_nxt.done = 1'b1;
                q_nxt.err_length = 1'b1;
                q_nxt.cnt = 8'h00;
                q_nxt.st = RX_HDR;
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs straight from state
    assign link.ready = q_r.ready;
    assign transport = q_r.transport;
    assign hdr = q_r.hdr;
    assign hdr_valid = q_r.hdr_valid;
    assign sec = q_r.sec;
    assign sec_valid = q_r.sec_valid;
    assign msg_done = q_r.done;
    assign err_version = q_r.err_version;
    assign err_kind = q_r.err_kind;
    assign err_length = q_r.err_length;
    assign err_ext = q_r.err_ext;

endmodule // idle_guard_receiver

// file: verilog/idle_guard_params.svh
// Constants for the idle/guard control-plane framer pair.
// Assumes inclusion by the package only; offsets are octet number minus one.
`ifndef IDLE_GUARD_PARAMS_SVH
`define IDLE_GUARD_PARAMS_SVH

// ==========================================
// Message header octet offsets
`define IG_TRANSPORT_OCTETS 8'h08
`define IG_OCT_VERSION 8'h08
`define IG_OCT_FRAME 8'h09
`define IG_OCT_SLOT_HI 8'h0A
`define IG_OCT_SLOT_LO 8'h0B
`define IG_OCT_COUNT 8'h0C
`define IG_OCT_KIND 8'h0D
`define IG_OCT_SHIFT_HI 8'h0E
`define IG_OCT_SHIFT_LO 8'h0F
`define IG_OCT_FFT 8'h10
`define IG_OCT_CP_HI 8'h11
`define IG_OCT_CP_LO 8'h12
`define IG_OCT_RESERVED 8'h13

// ==========================================
// Section description octet offsets
`define IG_SEC_TAG_HI 8'h00
`define IG_SEC_TAG_LO 8'h01
`define IG_SEC_BLOCK_LO 8'h02
`define IG_SEC_COUNT 8'h03
`define IG_SEC_MASK_HI 8'h04
`define IG_SEC_MASK_LO 8'h05
`define IG_SEC_FLAG 8'h06
`define IG_SEC_LAST 8'h07

// ==========================================
// Field values and extension sizing
`define IG_FORMAT_VERSION 3'h1
`define IG_KIND_IDLE 8'h00
`define IG_EXT_WORD_BYTES 10'h004
`define IG_EXT_HDR_BYTES 10'h002

`endif

// file: verilog/idle_guard_pkg.sv
// Types shared by both ends of the framer pair, and the octet packing used by the sender.
// Assumes the params header sits in the include path.
`include "idle_guard_params.svh"

package idle_guard_pkg;

    // ==========================================
    // Field groups
    typedef struct packed {
        logic tx_rx_direction;
        logic [2:0] format_version;
        logic [3:0] channel_filter_select;
        logic [7:0] radio_frame_number;
        logic [3:0] subframe_number;
        logic [5:0] slot_number;
        logic [5:0] first_symbol_number;
        logic [7:0] section_count;
        logic [7:0] section_kind;
        logic [15:0] timing_shift;
        logic [7:0] fft_and_spacing_code;
        logic [15:0] cyclic_prefix_size;
    } hdr_t;

    typedef struct packed {
        logic [11:0] section_tag;
        logic alternate_block_indicator;
        logic symbol_step_command;
        logic [9:0] first_block_index;
        logic [7:0] block_count;
        logic [11:0] element_mask;
        logic [3:0] symbol_count;
        logic more_extensions_flag;
        logic [6:0] extension_kind;
        logic [7:0] extension_word_length;
    } sec_t;

    typedef enum logic [2:0] {RX_HDR, RX_SEC, RX_EXT, RX_SKIP, RX_DRAIN} rx_state_t;
    typedef enum logic [2:0] {TX_IDLE, TX_HDR, TX_WAIT, TX_SEC, TX_EXT} tx_state_t;

    // ==========================================
    // Application header octet, msb first
    function automatic logic [7:0] hdr_byte(input hdr_t h, input logic [7:0] idx);
        unique case (idx)
            `IG_OCT_VERSION: hdr_byte = {h.tx_rx_direction, h.format_version,
                                         h.channel_filter_select};
            `IG_OCT_FRAME: hdr_byte = h.radio_frame_number;
            `IG_OCT_SLOT_HI: hdr_byte = {h.subframe_number, h.slot_number[5:2]};
            `IG_OCT_SLOT_LO: hdr_byte = {h.slot_number[1:0], h.first_symbol_number};
            `IG_OCT_COUNT: hdr_byte = h.section_count;
            `IG_OCT_KIND: hdr_byte = h.section_kind;
            `IG_OCT_SHIFT_HI: hdr_byte = h.timing_shift[15:8];
            `IG_OCT_SHIFT_LO: hdr_byte = h.timing_shift[7:0];
            `IG_OCT_FFT: hdr_byte = h.fft_and_spacing_code;
            `IG_OCT_CP_HI: hdr_byte = h.cyclic_prefix_size[15:8];
            `IG_OCT_CP_LO: hdr_byte = h.cyclic_prefix_size[7:0];
            default: hdr_byte = 8'h00;
        endcase
    endfunction

    // Section description octet, reserved bits zero
    function automatic logic [7:0] sec_byte(input sec_t s, input logic [7:0] idx);
        unique case (idx)
            `IG_SEC_TAG_HI: sec_byte = s.section_tag[11:4];
            `IG_SEC_TAG_LO: sec_byte = {s.section_tag[3:0], s.alternate_block_indicator,
                                        s.symbol_step_command, s.first_block_index[9:8]};
            `IG_SEC_BLOCK_LO: sec_byte = s.first_block_index[7:0];
            `IG_SEC_COUNT: sec_byte = s.block_count;
            `IG_SEC_MASK_HI: sec_byte = s.element_mask[11:4];
            `IG_SEC_MASK_LO: sec_byte = {s.element_mask[3:0], s.symbol_count};
            `IG_SEC_FLAG: sec_byte = {s.more_extensions_flag, 7'h00};
            default: sec_byte = 8'h00;
        endcase
    endfunction

endpackage

// file: verilog/idle_guard_link_if.sv
// Octet stream between the distributed unit and the radio unit.
// Assumes both ends share one clock; the testbench owns that clock.
`timescale 1ns/10ps

interface idle_guard_link_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    logic last;

    // Sending end drives octets, receiving end drives ready
    modport distributed_unit (output valid, output data, output last, input ready);
    modport radio_unit (input valid, input data, input last, output ready);
endinterface

// file: verilog/idle_guard_sender.sv
// Distributed unit end: frames idle/guard messages onto the octet link.
// Assumes the user holds sec_valid with section data until sec_ready takes it.
`timescale 1ns/10ps

module idle_guard_sender (
    input wire logic clock,
    input wire logic resetn,
    input wire logic start,
    input wire logic [63:0] transport_in,
    input wire idle_guard_pkg::hdr_t hdr_in,
    input wire logic sec_valid,
    input wire idle_guard_pkg::sec_t sec_in,
    output logic sec_ready,
    output logic busy,
    idle_guard_link_if.distributed_unit link
);
    import idle_guard_pkg::*;

    typedef struct packed {
        tx_state_t st;
        logic [9:0] cnt;
        logic [7:0] left;
        logic [63:0] transport;
        hdr_t hdr;
        sec_t sec;
        logic valid;
        logic [7:0] data;
        logic last;
        logic sec_ready;
        logic busy;
    } tx_t;

    tx_t q_r;
    tx_t q_nxt;
    logic load;
    logic sec_end;

    // ==========================================
    // Octet sequencing
    always_comb begin
        q_nxt = q_r;
        sec_end = 1'b0;
        load = !q_r.valid || link.ready;
        if (load) begin
            q_nxt.valid = 1'b0;
            q_nxt.last = 1'b0;
        end
        unique case (q_r.st)
            TX_IDLE: begin
                if (load) begin
                    q_nxt.busy = 1'b0;
                end
                if (start && !q_r.busy) begin
                    q_nxt.transport = transport_in;
                    q_nxt.hdr = hdr_in;
                    q_nxt.hdr.format_version = `IG_FORMAT_VERSION;
                    q_nxt.hdr.section_kind = `IG_KIND_IDLE;
                    q_nxt.left = hdr_in.section_count;
                    q_nxt.cnt = 10'h000;
                    q_nxt.busy = 1'b1;
                    q_nxt.st = TX_HDR;
                end
            end
            TX_HDR: begin
                if (load) begin
                    q_nxt.valid = 1'b1;
                    q_nxt.cnt = q_r.cnt + 10'h001;
                    if (q_r.cnt[7:0] < `IG_TRANSPORT_OCTETS) begin
                        q_nxt.data = q_r.transport[63:56];
                        q_nxt.transport = {q_r.transport[55:0], 8'h00};
                    end else begin
                        q_nxt.data = hdr_byte(q_r.hdr, q_r.cnt[7:0]);
                    end
                    if (q_r.cnt[7:0] == `IG_OCT_RESERVED) begin
                        q_nxt.cnt = 10'h000;
                        if (q_r.left == 8'h00) begin
                            q_nxt.last = 1'b1;
                            q_nxt.st = TX_IDLE;
                        end else begin
                            q_nxt.sec_ready = 1'b1;
                            q_nxt.st = TX_WAIT;
                        end
                    end
                end
            end
            TX_WAIT: begin
                if (q_r.sec_ready && sec_valid) begin
                    q_nxt.sec = sec_in;
                    if (sec_in.extension_word_length == 8'h00) begin
                        q_nxt.sec.extension_word_length = 8'h01;
                    end
                    q_nxt.sec_ready = 1'b0;
                    q_nxt.st = TX_SEC;
                end
            end
            TX_SEC: begin
                if (load) begin
                    q_nxt.valid = 1'b1;
                    q_nxt.data = sec_byte(q_r.sec, q_r.cnt[7:0]);
                    q_nxt.cnt = q_r.cnt + 10'h001;
                    if (q_r.cnt[7:0] == `IG_SEC_LAST) begin
                        q_nxt.cnt = 10'h000;
                        if (q_r.sec.more_extensions_flag) begin
                            q_nxt.st = TX_EXT;
                        end else begin
                            sec_end = 1'b1;
                        end
                    end
                end
            end
            TX_EXT: begin
                if (load) begin
                    q_nxt.valid = 1'b1;
                    q_nxt.cnt = q_r.cnt + 10'h001;
                    if (q_r.cnt == 10'h000) begin
                        q_nxt.data = {1'b0, q_r.sec.extension_kind};
                    end else if (q_r.cnt == 10'h001) begin
                        q_nxt.data = q_r.sec.extension_word_length;
                    end else begin
                        q_nxt.data = 8'h00;
                    end
                    if (q_r.cnt == {q_r.sec.extension_word_length, 2'b00} - 10'h001) begin
                        q_nxt.cnt = 10'h000;
                        sec_end = 1'b1;
                    end
                end
            end
        endcase
        if (sec_end) begin
            q_nxt.left = q_r.left - 8'h01;
            if (q_r.left == 8'h01) begin
                q_nxt.last = 1'b1;
                q_nxt.st = TX_IDLE;
            end else begin
                q_nxt.sec_ready = 1'b1;
                q_nxt.st = TX_WAIT;
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Outputs straight from state
    assign link.valid = q_r.valid;
    assign link.data = q_r.data;
    assign link.last = q_r.last;
    assign sec_ready = q_r.sec_ready;
    assign busy = q_r.busy;

endmodule // idle_guard_sender

// file: dv/idle_guard_link_properties.sv
// Link checker: octet handshake and fixed header octets of each message.
// Assumes one clock for both ends; tb instantiates it beside the link.
`timescale 1ns/10ps

module idle_guard_link_properties (
    input wire logic clock,
    input wire logic resetn,
    input wire logic valid,
    input wire logic ready,
    input wire logic [7:0] data,
    input wire logic last
);
    logic [9:0] octet_r;
    logic [9:0] octet_nxt;
    logic take;
    // ==========================================
    // Octet position within the message
    assign take = valid && ready;
    always_comb begin
        octet_nxt = octet_r;
        if (take) begin
            octet_nxt = last ? 10'h000 : octet_r + 10'h001;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            octet_r <= 10'h000;
        end else begin
            octet_r <= octet_nxt;
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    a_octet_held: assert property (valid && !ready |=> valid && $stable(data) && $stable(last))
        else $error("octet changed before take");
    a_ready_after_reset: assert property ($past(resetn) |-> ready)
        else $error("receiver not ready");
    a_last_with_valid: assert property (last |-> valid)
        else $error("last without valid");
    a_gap_after_last: assert property (take && last |=> !valid)
        else $error("no gap after message");
    a_version_one: assert property (take && octet_r == 10'h008 |-> data[6:4] == 3'h1)
        else $error("format version not one");
    a_kind_zero: assert property (take && octet_r == 10'h00d |-> data == 8'h00)
        else $error("section kind not zero");
    a_reserved_zero: assert property (take && octet_r == 10'h013 |-> data == 8'h00)
        else $error("reserved octet not zero");
    a_header_length: assert property (take && last |-> octet_r >= 10'h013)
        else $error("message shorter than header");
    c_msg_end: cover property (take && last);
    c_first_section: cover property (take && octet_r == 10'h014);
    c_stall: cover property (octet_r != 10'h000 && !valid);
endmodule // idle_guard_link_properties

// file: dv/tb.sv
// Testbench: sender and receiver joined by the link, messages with and without sections.
// Assumes design files and the link checker are compiled first.
`timescale 1ns/10ps

module tb;
    import idle_guard_pkg::*;
    // ==========================================
    // Signals
    logic clock = 1'b0, resetn = 1'b0, start = 1'b0, sec_valid = 1'b0;
    logic [63:0] transport_in = 64'h0123_4567_89ab_cdef;
    logic [63:0] transport;
    hdr_t hdr_in = '0;
    hdr_t hdr, got_hdr;
    sec_t sec_in = '0;
    sec_t sec;
    sec_t got[$];
    logic hdr_valid, rx_valid, msg_done, sec_ready, busy;
    logic err_version, err_kind, err_length, err_ext;
    int err_count = 0, checked = 0, dones = 0;
    idle_guard_link_if link ();
    idle_guard_sender idle_guard_sender_inst (.clock(clock), .resetn(resetn), .start(start),
        .transport_in(transport_in), .hdr_in(hdr_in), .sec_valid(sec_valid), .sec_in(sec_in),
        .sec_ready(sec_ready), .busy(busy), .link(link));
    idle_guard_receiver idle_guard_receiver_inst (.clock(clock), .resetn(resetn), .link(link),
        .transport(transport), .hdr(hdr), .hdr_valid(hdr_valid), .sec(sec), .sec_valid(rx_valid),
        .msg_done(msg_done), .err_version(err_version), .err_kind(err_kind),
        .err_length(err_length), .err_ext(err_ext));
    idle_guard_link_properties idle_guard_link_properties_inst (.clock(clock), .resetn(resetn),
        .valid(link.valid), .ready(link.ready), .data(link.data), .last(link.last));
    // Clock
    always #2.5 clock = ~clock;
    // Capture receiver pulses mid-cycle
    always @(negedge clock) begin
        if (hdr_valid === 1'b1) got_hdr = hdr;
        if (rx_valid === 1'b1) got.push_back(sec);
        if (msg_done === 1'b1) dones++;
    end
    // ==========================================
    // Shared tasks
    task automatic cmp(input logic [87:0] g, input logic [87:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic send(input hdr_t h, input sec_t s[$]);
        int d;
        d = dones;
        got.delete();
        hdr_in <= h;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        foreach (s[i]) begin
            sec_in <= s[i];
            sec_valid <= 1'b1;
            @(negedge clock);
            while (sec_ready !== 1'b1) @(negedge clock);
            @(posedge clock);
        end
        sec_valid <= 1'b0;
        while (dones == d || busy !== 1'b0) @(negedge clock);
        // Return on a rising edge so the next drive lands there
        @(posedge clock);
    endtask
    task automatic stop_test();
        $display("Checks %0d, errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic test_two_sections();
        hdr_t h, e;
        sec_t s[$], x;
        h = 88'hc7_1e9b_0207_1234_56ff_abcd;
        h.section_count = 8'h02;
        e = h;
        e.format_version = 3'h1;
        e.section_kind = 8'h00;
        s = '{64'h5a3c_d7e1_9f64_0000, 64'ha5c3_2b18_e6f9_aa02};
        // Extension fields lag until the extension octets arrive
        x = s[1];
        x.extension_kind = 7'h00;
        x.extension_word_length = 8'h00;
        send(h, s);
        cmp(transport, transport_in);
        cmp(got_hdr, e);
        cmp(got.size(), 2);
        cmp(got[0], s[0]);
        cmp(got[1], x);
        cmp(sec, s[1]);
        cmp(dones, 1);
        cmp({err_version, err_kind, err_length, err_ext}, 4'h0);
    endtask
    task automatic test_empty_extension();
        hdr_t h;
        sec_t s[$], e;
        h = 88'h10_0000_0001_0000_0000_0000;
        s = '{64'h0010_0000_0000_9100};
        // Zero length goes out as one word
        e = s[0];
        e.extension_word_length = 8'h01;
        send(h, s);
        cmp(sec, e);
        cmp(got.size(), 1);
        cmp(dones, 2);
        cmp({err_version, err_kind, err_length, err_ext}, 4'h0);
    endtask
    task automatic test_no_sections();
        hdr_t h;
        sec_t s[$];
        h = 88'h1a_5c38_e100_00f3_edcb_a900;
        transport_in <= 64'hfedc_ba98_7654_3210;
        send(h, s);
        cmp(transport, 64'hfedc_ba98_7654_3210);
        cmp(got_hdr, h);
        cmp(got.size(), 0);
        cmp(dones, 3);
        cmp({err_version, err_kind, err_length, err_ext}, 4'h0);
    endtask
    // ==========================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        test_two_sections();
        test_empty_extension();
        test_no_sections();
        stop_test();
    end
    initial begin
        #50000;
        err_count++;
        stop_test();
    end
endmodule // tb
